// ==== src/hss_pkg.sv ====
// Summary of operation
// - off: gates off, wait for valid start
// - insertion delay: gates off, abort on range
// - insertion done advances to start-up
// - start-up closes soft-start switch to gate
// - start-up uses reduced gate sourcing current
// - start-up forces low limit and trip levels
// - start-up faults return to off
// - filtered power good moves to normal
// - normal opens the soft-start switch
// - normal uses full gate sourcing current
// - normal thresholds follow drain-sense comparator
// - normal exits on good loss, timeout, lockout
// - normal over/under-voltage or trip fault: gate off, stay
// - raw good needs both gates, low drain
// - input range excludes over, under, lockout
// - timeout held through all restart cycles
// - fixed count of cool-down cycles before restart
package hss_pkg;

  // ==========================================
  // timing
  localparam int CLK_MHZ      = 50;
  localparam int DEGL_NS      = 1000;
  localparam int DEGL_CYCLES  = (DEGL_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_CYCLES = 63;

  // ==========================================
  // register map
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0]  OFS_IRQ_EN   = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;
  localparam int          CTRL_EN_BIT  = 0;
  localparam logic        CTRL_EN_RST  = 1'h1;
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_FAULT    = 0;
  localparam int          IRQ_NORMAL   = 1;
  localparam int          IRQ_PGLOST   = 2;
  localparam int          IRQ_TIMEOUT  = 3;
  localparam int          ST_INRANGE   = 2;
  localparam int          ST_PGRAW     = 3;
  localparam int          ST_PGFILT    = 4;
  localparam int          ST_TIMEOUT   = 5;
  localparam int          ST_RETRY     = 6;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    HSS_OFF    = 2'h0,
    HSS_INSERT = 2'h1,
    HSS_START  = 2'h3,
    HSS_NORMAL = 2'h2
  } hss_state_t;

  typedef struct packed {
    logic overVoltage;
    logic underVoltage;
    logic supplyLockout;
    logic insertionDone;
    logic severeOvercurrentFlag;
    logic timerTripped;
    logic drainSenseHigh;
    logic drainBelowGoodLevel;
    logic gateEnhanced;
    logic timerAtLow;
    logic timerAtHigh;
    logic timerEmpty;
  } hss_sense_t;

  typedef struct packed {
    logic gateOn;
    logic gateFullSource;
    logic softStartClosed;
    logic softStartDischarge;
    logic secondGateDrive;
    logic highVdsLimitLevel;
    logic startupTripLevel;
    logic timerSink;
    logic timerSource;
  } hss_drive_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrStrobe;
    logic              rdStrobe;
  } hss_bus_t;

endpackage : hss_pkg

// ==== src/hss_deglitch.sv ====
`timescale 1ns/10ps
`default_nettype none
module hss_deglitch #(
  parameter int CYCLES = 50
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic rawIn,
  output var  logic filtOut
);
  import hss_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_chk
    $error("deglitch length must be at least one cycle");
  end

  typedef struct packed {
    logic          filt;
    logic [CW-1:0] cnt;
  } hss_degl_t;

  hss_degl_t st_r;
  hss_degl_t st_nxt;

  // ==========================================
  // follow the raw level once it holds steady
  always_comb begin
    st_nxt = st_r;
    if (rawIn == st_r.filt) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CW'(CYCLES - 1)) begin
      st_nxt.filt = rawIn;
      st_nxt.cnt  = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filtOut = st_r.filt;

endmodule : hss_deglitch
`default_nettype wire

// ==== src/hss_retry_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module hss_retry_timer #(
  parameter int RETRIES = 63
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         timerTripped,
  input  wire logic                         timerAtLow,
  input  wire logic                         timerAtHigh,
  input  wire logic                         timerEmpty,
  output var  logic                         timeOut,
  output var  logic                         timerSink,
  output var  logic                         timerSource,
  output var  logic [$clog2(RETRIES+1)-1:0] retryCount
);
  import hss_pkg::*;

  localparam int CW = $clog2(RETRIES + 1);

  if (RETRIES < 1) begin : g_chk
    $error("retry count must be at least one");
  end

  typedef enum logic [1:0] {
    RT_IDLE  = 2'h0,
    RT_DIS   = 2'h1,
    RT_CHG   = 2'h3,
    RT_FINAL = 2'h2
  } hss_rt_state_t;

  typedef struct packed {
    hss_rt_state_t ph;
    logic [CW-1:0] cnt;
  } hss_rt_t;

  hss_rt_t st_r;
  hss_rt_t st_nxt;

  // ==========================================
  // cool-down discharge / recharge loop
  always_comb begin
    st_nxt = st_r;
    case (st_r.ph)
      RT_IDLE: begin
        st_nxt.cnt = '0;
        if (timerTripped) begin
          st_nxt.ph = RT_DIS;
        end
      end
      RT_DIS: begin
        if (timerAtLow) begin
          st_nxt.ph = RT_CHG;
        end
      end
      RT_CHG: begin
        if (timerAtHigh) begin
          st_nxt.cnt = st_r.cnt + CW'(1);
          if (st_r.cnt == CW'(RETRIES - 1)) begin
            st_nxt.ph = RT_FINAL;
          end else begin
            st_nxt.ph = RT_DIS;
          end
        end
      end
      RT_FINAL: begin
        if (timerEmpty) begin
          st_nxt.ph = RT_IDLE;
        end
      end
      default: st_nxt.ph = RT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{ph: RT_IDLE, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timeOut     = (st_r.ph != RT_IDLE);
  assign timerSink   = (st_r.ph == RT_DIS) || (st_r.ph == RT_FINAL);
  assign timerSource = (st_r.ph == RT_CHG);
  assign retryCount  = st_r.cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_timeout_held: assert property (timeOut && st_r.ph != RT_FINAL |=> timeOut)
    else $error("timeout dropped before restart cycles ended");
  a_retry_final: assert property (st_r.ph == RT_CHG && timerAtHigh && st_r.cnt == CW'(RETRIES - 1)
    |=> st_r.ph == RT_FINAL && retryCount == CW'(RETRIES))
    else $error("final discharge not entered after last cycle");
  a_retry_early: assert property (st_r.ph == RT_CHG && timerAtHigh && st_r.cnt < CW'(RETRIES - 1)
    |=> st_r.ph == RT_DIS)
    else $error("cool-down loop ended early");

endmodule : hss_retry_timer
`default_nettype wire

// ==== src/hss_sequencer.sv ====
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hss_sequencer #(
  parameter int DEGL = hss_pkg::DEGL_CYCLES,
  parameter int RETRIES = hss_pkg::RETRY_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire hss_pkg::hss_sense_t       sense,
  input  wire hss_pkg::hss_bus_t         bus,
  output var  hss_pkg::hss_drive_t       drive,
  output var  logic                      inputInRange,
  output var  logic                      powerGoodRaw,
  output var  logic                      powerGoodFiltered,
  output var  logic                      powerGoodOutN,
  output var  logic                      timeOut,
  output var  logic [hss_pkg::DATA_W-1:0] rdData,
  output var  logic                      irq
);
  import hss_pkg::*;

  localparam int RCW = $clog2(RETRIES + 1);

  if (RCW > DATA_W - ST_RETRY || DEGL < 1) begin : g_chk
    $error("retry count too wide for status word or deglitch length zero");
  end

  typedef struct packed {
    hss_state_t       state;
    logic             enable;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqEnable;
    logic [DATA_W-1:0] rdData;
    logic             pgPrev;
    logic             toPrev;
  } hss_seq_t;

  hss_seq_t        st_r;
  hss_seq_t        st_nxt;
  logic [RCW-1:0]  retryCount;
  logic            faultStart;
  logic            normalHold;
  logic [IRQ_W-1:0] events;
  logic [DATA_W-1:0] rdMux;
  logic              tmrSink;
  logic              tmrSource;

  // ==========================================
  // helpers
  hss_deglitch #(
    .CYCLES (DEGL)
  ) u_degl (
    .clock   (clock),
    .rst_n   (rst_n),
    .rawIn   (powerGoodRaw),
    .filtOut (powerGoodFiltered)
  );

  hss_retry_timer #(
    .RETRIES (RETRIES)
  ) u_retry (
    .clock        (clock),
    .rst_n        (rst_n),
    .timerTripped (sense.timerTripped),
    .timerAtLow   (sense.timerAtLow),
    .timerAtHigh  (sense.timerAtHigh),
    .timerEmpty   (sense.timerEmpty),
    .timeOut      (timeOut),
    .timerSink    (tmrSink),
    .timerSource  (tmrSource),
    .retryCount   (retryCount)
  );

  // ==========================================
  // analog condition decode
  assign inputInRange = !sense.overVoltage && !sense.underVoltage
                        && !sense.supplyLockout;
  assign faultStart   = !inputInRange || timeOut
                        || sense.severeOvercurrentFlag;
  assign normalHold   = !inputInRange || sense.severeOvercurrentFlag;

  // ==========================================
  // gate and threshold drive
  always_comb begin
    drive.gateOn             = 1'b0;
    drive.gateFullSource     = 1'b0;
    drive.softStartClosed    = 1'b0;
    drive.softStartDischarge = 1'b1;
    drive.secondGateDrive    = 1'b0;
    drive.highVdsLimitLevel  = 1'b1;
    drive.startupTripLevel   = 1'b1;
    drive.timerSink          = tmrSink;
    drive.timerSource        = tmrSource;
    case (st_r.state)
      HSS_OFF, HSS_INSERT: begin
        drive.gateOn = 1'b0;
      end
      HSS_START: begin
        drive.gateOn             = 1'b1;
        drive.softStartClosed    = 1'b1;
        drive.softStartDischarge = 1'b0;
        drive.gateFullSource     = 1'b0;
        drive.secondGateDrive    = sense.gateEnhanced;
        drive.highVdsLimitLevel  = 1'b1;
        drive.startupTripLevel   = 1'b1;
      end
      HSS_NORMAL: begin
        drive.gateOn             = !normalHold;
        drive.softStartClosed    = 1'b0;
        drive.softStartDischarge = 1'b0;
        drive.gateFullSource     = 1'b1;
        drive.secondGateDrive    = !normalHold && sense.gateEnhanced;
        drive.highVdsLimitLevel  = sense.drainSenseHigh;
        drive.startupTripLevel   = sense.drainSenseHigh;
      end
      default: begin
        drive.gateOn = 1'b0;
      end
    endcase
  end

  assign powerGoodRaw  = drive.gateOn && drive.secondGateDrive
                         && sense.drainBelowGoodLevel;
  assign powerGoodOutN = !powerGoodFiltered;

  // ==========================================
  // register read mux
  always_comb begin
    rdMux = '0;
    case (bus.addr)
      OFS_CTRL: begin
        rdMux[CTRL_EN_BIT] = st_r.enable;
      end
      OFS_STATUS: begin
        rdMux[1:0]                   = st_r.state;
        rdMux[ST_INRANGE]            = inputInRange;
        rdMux[ST_PGRAW]              = powerGoodRaw;
        rdMux[ST_PGFILT]             = powerGoodFiltered;
        rdMux[ST_TIMEOUT]            = timeOut;
        rdMux[ST_RETRY +: RCW]       = retryCount;
      end
      OFS_IRQ_STAT: begin
        rdMux[IRQ_W-1:0] = st_r.irqStatus;
      end
      OFS_IRQ_EN: begin
        rdMux[IRQ_W-1:0] = st_r.irqEnable;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // ==========================================
  // sequencer and registers
  always_comb begin
    st_nxt        = st_r;
    st_nxt.pgPrev = powerGoodFiltered;
    st_nxt.toPrev = timeOut;
    case (st_r.state)
      HSS_OFF: begin
        if (st_r.enable && inputInRange && !timeOut) begin
          st_nxt.state = HSS_INSERT;
        end
      end
      HSS_INSERT: begin
        if (!inputInRange || !st_r.enable) begin
          st_nxt.state = HSS_OFF;
        end else if (sense.insertionDone) begin
          st_nxt.state = HSS_START;
        end
      end
      HSS_START: begin
        if (faultStart || !st_r.enable) begin
          st_nxt.state = HSS_OFF;
        end else if (powerGoodFiltered) begin
          st_nxt.state = HSS_NORMAL;
        end
      end
      HSS_NORMAL: begin
        if (!powerGoodFiltered || timeOut || sense.supplyLockout
            || !st_r.enable) begin
          st_nxt.state = HSS_OFF;
        end
      end
      default: begin
        st_nxt.state = HSS_OFF;
      end
    endcase
    events              = '0;
    events[IRQ_FAULT]   = (st_r.state != HSS_OFF) && (st_nxt.state == HSS_OFF);
    events[IRQ_NORMAL]  = (st_r.state != HSS_NORMAL) && (st_nxt.state == HSS_NORMAL);
    events[IRQ_PGLOST]  = st_r.pgPrev && !powerGoodFiltered;
    events[IRQ_TIMEOUT] = !st_r.toPrev && timeOut;
    if (bus.wrStrobe && bus.addr == OFS_CTRL) begin
      st_nxt.enable = bus.wrData[CTRL_EN_BIT];
    end
    if (bus.wrStrobe && bus.addr == OFS_IRQ_EN) begin
      st_nxt.irqEnable = bus.wrData[IRQ_W-1:0];
    end
    st_nxt.irqStatus = st_r.irqStatus | events;
    if (bus.wrStrobe && bus.addr == OFS_IRQ_CLR) begin
      st_nxt.irqStatus = (st_r.irqStatus & ~bus.wrData[IRQ_W-1:0]) | events;
    end
    st_nxt.rdData = bus.rdStrobe ? rdMux : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: HSS_OFF, enable: CTRL_EN_RST, irqStatus: '0,
                irqEnable: '0, rdData: '0, pgPrev: 1'b0, toPrev: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign irq    = |(st_r.irqStatus & st_r.irqEnable);

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_startFault;
    st_r.state == HSS_START && faultStart;
  endsequence

  sequence s_normalGlitch;
    st_r.state == HSS_NORMAL && normalHold && powerGoodFiltered
    && !timeOut && !sense.supplyLockout && st_r.enable;
  endsequence

  property p_fallsOff(s);
    s |=> st_r.state == HSS_OFF;
  endproperty

  sequence s_enterNormal;
    st_r.state != HSS_NORMAL ##1 st_r.state == HSS_NORMAL;
  endsequence

  a_gate_idle_off: assert property (st_r.state inside {HSS_OFF, HSS_INSERT}
    |-> !drive.gateOn && !drive.secondGateDrive && !drive.softStartClosed)
    else $error("gate driven while idle");
  a_insert_abort: assert property (st_r.state == HSS_INSERT && !inputInRange
    |=> st_r.state == HSS_OFF)
    else $error("insertion delay not aborted");
  a_insert_done: assert property (st_r.state == HSS_INSERT && inputInRange && st_r.enable
    && sense.insertionDone |=> st_r.state == HSS_START)
    else $error("start-up not entered after insertion");
  a_start_drive: assert property (st_r.state == HSS_START
    |-> drive.softStartClosed && !drive.gateFullSource)
    else $error("start-up soft-start drive wrong");
  a_start_levels: assert property (st_r.state == HSS_START
    |-> drive.highVdsLimitLevel && drive.startupTripLevel)
    else $error("start-up thresholds not low");
  a_start_fault: assert property (p_fallsOff(s_startFault))
    else $error("start-up fault did not return to off");
  a_start_normal: assert property (st_r.state == HSS_START && !faultStart && st_r.enable
    && powerGoodFiltered |=> st_r.state == HSS_NORMAL)
    else $error("normal not entered on power good");
  a_normal_drive: assert property (st_r.state == HSS_NORMAL |-> !drive.softStartClosed
    && drive.gateFullSource && drive.highVdsLimitLevel == sense.drainSenseHigh)
    else $error("normal drive wrong");
  a_normal_exit: assert property (st_r.state == HSS_NORMAL && (!powerGoodFiltered || timeOut)
    |=> st_r.state == HSS_OFF)
    else $error("normal did not exit");
  a_normal_hold: assert property (s_normalGlitch |-> !drive.gateOn && !powerGoodRaw
    ##1 st_r.state == HSS_NORMAL)
    else $error("normal glitch handling wrong");
  a_good_raw: assert property (powerGoodRaw |-> drive.gateOn && drive.secondGateDrive
    && sense.drainBelowGoodLevel && st_r.state inside {HSS_START, HSS_NORMAL})
    else $error("raw power good without conditions");
  a_range_lock: assert property (sense.supplyLockout |-> !inputInRange
    ##1 st_r.state != HSS_NORMAL)
    else $error("lockout not seen as out of range");
  a_off_wait: assert property (st_r.state == HSS_OFF && (!inputInRange || timeOut)
    |=> st_r.state == HSS_OFF)
    else $error("left off while out of range or retrying");
  a_normal_entry: assert property (s_enterNormal |-> $past(st_r.state) == HSS_START
    && $past(powerGoodFiltered))
    else $error("normal entered without filtered power good");
  a_normal_soft: assert property (st_r.state == HSS_NORMAL
    |-> !drive.softStartClosed && !drive.softStartDischarge)
    else $error("soft-start pin not released in normal");
  a_normal_lock: assert property (st_r.state == HSS_NORMAL && sense.supplyLockout
    |=> st_r.state == HSS_OFF)
    else $error("lockout did not end normal");
  a_second_gate_drive_main: assert property (drive.secondGateDrive
    |-> drive.gateOn && sense.gateEnhanced)
    else $error("second gate on without enhanced main gate");
  a_irq_sticky: assert property (!(bus.wrStrobe && bus.addr == OFS_IRQ_CLR)
    |=> (st_r.irqStatus & $past(st_r.irqStatus)) == $past(st_r.irqStatus))
    else $error("interrupt status bit lost without clear");
  a_rd_idle: assert property (!$past(bus.rdStrobe) |-> rdData == '0)
    else $error("read data not zero outside read cycle");

endmodule : hss_sequencer
`default_nettype wire

// ==== bench/hss_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module hss_far_model (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire hss_pkg::hss_drive_t drive,
  input  wire logic [6:0]          ctl,
  output var  hss_pkg::hss_sense_t sense
);
  import hss_pkg::*;
  logic       enhanced;
  logic [3:0] tmrLvl;
  // ==========================================
  // gate enhancement lags gate, timer cap level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enhanced <= 1'b0;
      tmrLvl   <= 4'h0;
    end else begin
      enhanced <= drive.gateOn;
      if (drive.timerSource && tmrLvl != 4'hF)
        tmrLvl <= tmrLvl + 4'h1;
      else if (drive.timerSink && tmrLvl != 4'h0)
        tmrLvl <= tmrLvl - 4'h1;
    end
  end
  // ==========================================
  // comparator outputs
  always_comb begin
    sense = '0;
    {sense.overVoltage, sense.underVoltage, sense.supplyLockout, sense.insertionDone,
     sense.severeOvercurrentFlag, sense.timerTripped, sense.drainSenseHigh} = ctl;
    sense.gateEnhanced        = enhanced;
    sense.drainBelowGoodLevel = enhanced;
    sense.timerAtLow          = tmrLvl <= 4'h2;
    sense.timerAtHigh         = tmrLvl >= 4'h6;
    sense.timerEmpty          = tmrLvl == 4'h0;
  end
endmodule : hss_far_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hss_pkg::*;
  localparam int         DG = 4;
  localparam int         RT = 3;
  localparam logic [6:0] OK = 7'h00, OV = 7'h40, UV = 7'h20, LK = 7'h10;
  localparam logic [6:0] INS = 7'h08, SEV = 7'h04, TRP = 7'h02, DSH = 7'h01;
  localparam logic [6:0] OUTS [3] = '{OV, UV, LK};
  localparam logic [6:0] CAUSE [4] = '{OV, LK, SEV, LK};
  logic        clock;
  logic        rst_n;
  logic [6:0]  ctl;
  hss_sense_t  sense;
  hss_bus_t    bus;
  hss_drive_t  drive;
  logic        inRange, pgRaw, pgFilt, pgOutN, timeOut, irq, src, on;
  logic        rdSeen = 1'b0;
  logic [31:0] rdData, rnd;
  logic [31:0] expQ [$];
  int          err_total, n_tests, cycles, rises, i;

  hss_far_model u_far (.clock(clock), .rst_n(rst_n), .drive(drive), .ctl(ctl), .sense(sense));
  hss_sequencer #(.DEGL(DG), .RETRIES(RT)) u_dut (
    .clock(clock), .rst_n(rst_n), .sense(sense), .bus(bus), .drive(drive),
    .inputInRange(inRange), .powerGoodRaw(pgRaw), .powerGoodFiltered(pgFilt),
    .powerGoodOutN(pgOutN), .timeOut(timeOut), .rdData(rdData), .irq(irq));

  always #10 clock = ~clock;
  // ==========================================
  // helpers
  task automatic results();
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] stv(input hss_state_t s, input logic [3:0] f);
    return {26'h0, f, s};
  endfunction : stv
  task automatic go(input logic [6:0] v, input int n);
    @(posedge clock);
    ctl <= v;
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wrStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge clock);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus.rdStrobe <= 1'b0;
  endtask : rd
  task automatic toStart();
    go(OK, 2);
    go(INS, 1);
  endtask : toStart
  task automatic waitNorm();
    for (int k = 0; k < 30 && pgFilt !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
  endtask : waitNorm
  // ==========================================
  // read monitor and watchdog
  always @(posedge clock) begin
    if (rdSeen)
      chk("rdData", rdData, expQ.pop_front());
    rdSeen <= bus.rdStrobe;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ctl = OV;
    bus = '0;
    void'($urandom(32'hde54));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("resetOuts", {drive.gateOn, drive.secondGateDrive, drive.softStartClosed, pgOutN, timeOut, irq,
                      drive.softStartDischarge}, 7'h09);
    rd(OFS_CTRL, 32'h1);
    rd(8'h20, 32'h0);
    for (i = 0; i < 3; i++) begin
      go(OUTS[i], 3);
      chk("inRange", inRange, 1'b0);
      rd(OFS_STATUS, stv(HSS_OFF, 4'h0));
    end
    go(OK, 1);
    chk("insGate", drive.gateOn, 1'b0);
    rd(OFS_STATUS, stv(HSS_INSERT, 4'h1));
    for (i = 1; i < 3; i++) begin
      go(OUTS[i], 1);
      rd(OFS_STATUS, stv(HSS_OFF, 4'h0));
      go(OK, 1);
    end
    wr(OFS_IRQ_CLR, 32'hF);
    go(INS, 1);
    chk("start", {drive.gateOn, drive.softStartClosed, drive.gateFullSource, drive.highVdsLimitLevel,
      drive.startupTripLevel, pgRaw, drive.softStartDischarge}, 7'h6C);
    waitNorm();
    chk("normal", {drive.softStartClosed, drive.gateFullSource, pgRaw, pgOutN,
      drive.softStartDischarge}, 5'h0C);
    rd(OFS_STATUS, stv(HSS_NORMAL, 4'h7));
    go(INS | DSH, 0);
    chk("dsHigh", {drive.highVdsLimitLevel, drive.startupTripLevel}, 2'h3);
    go(INS, 0);
    chk("dsLow", {drive.highVdsLimitLevel, drive.startupTripLevel}, 2'h0);
    for (i = 0; i < 2; i++) begin
      go(INS | ((i == 0) ? SEV : OV), 0);
      chk("fastOff", {drive.gateOn, drive.secondGateDrive, pgRaw}, 3'h0);
      go(INS, DG + 4);
      rd(OFS_STATUS, stv(HSS_NORMAL, 4'h7));
    end
    go(INS | OV, DG + 3);
    rd(OFS_IRQ_STAT, 32'h7);
    rnd = $urandom;
    wr(OFS_IRQ_EN, rnd);
    rd(OFS_IRQ_EN, rnd & 32'hF);
    @(negedge clock);
    chk("irqMask", irq, |rnd[2:0]);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (2) @(negedge clock);
    chk("irqClr", irq, 1'b0);
    wr(OFS_IRQ_CLR, 32'hF);
    for (i = 0; i < 4; i++) begin
      toStart();
      if (i == 3)
        waitNorm();
      go(INS | CAUSE[i], 1);
      chk("exitGate", drive.gateOn, 1'b0);
      go(OV, DG + 2);
      chk("irqOff", irq, 1'b1);
      rd(OFS_IRQ_STAT, (i == 3) ? 32'h7 : 32'h1);
      wr(OFS_IRQ_CLR, 32'hF);
    end
    wr(OFS_IRQ_EN, 32'h8);
    toStart();
    go(INS | TRP, 0);
    go(INS, 2);
    chk("toOff", {timeOut, drive.gateOn}, 2'h2);
    rises = 0;
    src = 1'b0;
    on = 1'b0;
    for (i = 0; i < 600 && timeOut === 1'b1; i++) begin
      @(negedge clock);
      if (drive.timerSource === 1'b1 && src === 1'b0)
        rises++;
      src = drive.timerSource;
      on = on | drive.gateOn;
    end
    chk("retries", rises, RT);
    chk("heldOff", on, 1'b0);
    chk("irqTo", irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'h9);
    repeat (4) @(posedge clock);
    results();
  end
endmodule : tb
`default_nettype wire
